// ### verilog/insmp_consts.svh
// Register offsets, field positions, reset values and widths for the sampling monitor
`ifndef INSMP_CONSTS_SVH
`define INSMP_CONSTS_SVH
`define INSMP_OFS_FCTL 12'h000
`define INSMP_OFS_FLIN 12'h004
`define INSMP_OFS_FPHY 12'h008
`define INSMP_OFS_FRES 12'h00c
`define INSMP_OFS_OCTL 12'h010
`define INSMP_OFS_OPC 12'h014
`define INSMP_OFS_ORES 12'h018
`define INSMP_OFS_OCNT 12'h01c
`define INSMP_OFS_FCNT 12'h020
`define INSMP_CNT_W 20
`define INSMP_MAX_W 16
`define INSMP_LOW_W 4
`define INSMP_LFSR_W 7
`define INSMP_LAT_W 16
`define INSMP_CTL_EN 16
`define INSMP_CTL_VAL 17
`define INSMP_CTL_RAND 18
`define INSMP_LFSR_SEED 7'h5a
`define INSMP_RESP_OKAY 2'b00
`define INSMP_RESP_SLVERR 2'b10
`endif

// ### verilog/insmp_pkg.sv
// Types shared by the instruction sampling monitor
package insmp_pkg;
	typedef struct packed {
		logic [31:0] virt_addr;
		logic [31:0] phys_addr;
		logic phys_valid;
		logic [1:0] page_size;
		logic l1_miss;
		logic l2_miss;
		logic ic_miss;
	} insmp_fevt_t;
	typedef struct packed {
		logic l1_miss;
		logic l2_miss;
		logic ic_miss;
		logic phys_valid;
		logic [1:0] page_size;
		logic [31:0] phys_addr;
	} insmp_fupd_t;
	typedef struct packed {
		logic [31:0] pc;
		logic dc_miss;
		logic mispredict;
		logic branch;
	} insmp_oevt_t;
	typedef enum logic [2:0] {
		INSMP_F_IDLE = 3'b001,
		INSMP_F_ARMED = 3'b010,
		INSMP_F_TRACK = 3'b100
	} insmp_fstate_t;
endpackage

// ### verilog/insmp_monitor.sv
// Instruction sampling monitor: fetch and op sampling behind an AXI4-Lite slave
// Notes on behaviour
// - Fetch and op sampling have separate enables and may run together.
// - Fetch and op each own separate control and result registers.
// - Fetch counter increments per completed fetch while fetch sampling enabled, no fetch tagged and no sample pending.
// - Op counter increments every cycle up to the maximum while op sampling enabled, no op tagged and no sample pending.
// - At maximum fetch count the next attempted fetch is tagged.
// - Counters 20 bits; software writes top 16 maximum bits, low 4 zero.
// - Fetch counter clears when it reaches the maximum.
// - Optional randomization loads counter low 4 bits from 7-bit LFSR.
// - Tagged fetch completing or aborting raises interrupt and reports results.
// - Virtual fetch address always captured and treated as valid.
// - Physical valid flag set only when address and page size valid.
// - Separate L1 and L2 ITLB miss flags are sticky over all lookups of the tagged fetch.
// - Icache miss flag set when any access of the tagged fetch missed.
// - Completed flag set on delivery, clear on abort.
// - Latency counts cycles from tagged fetch start to delivery or abort.
// - Two-bit page size of the L1 ITLB translation is reported.
// - Events of the tagged fetch or op are recorded while processed.
// - Finished tagged item raises interrupt and its data becomes readable.
// - Only retiring tagged ops report data; flush gives no sample.
// - After flush, op counter reloads with random 7-bit value and retags.
`timescale 1ns/100ps
`include "insmp_consts.svh"
module insmp_monitor import insmp_pkg::*; (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite slave
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Fetch pipeline
	input wire logic fetch_start,
	input wire insmp_fevt_t fetch_info,
	input wire logic fetch_update,
	input wire insmp_fupd_t fetch_upd,
	input wire logic fetch_done,
	input wire logic fetch_abort,
	// Op pipeline
	output logic op_tag,
	input wire logic op_tag_taken,
	input wire logic op_event,
	input wire insmp_oevt_t op_info,
	input wire logic op_retire,
	input wire logic op_flush,
	// Sample interrupts
	output logic fetch_irq,
	output logic op_irq
);
	insmp_fstate_t fstate, next_fstate;
	logic [`INSMP_MAX_W-1:0] fmax, next_fmax, omax, next_omax;
	logic fen, next_fen, fval, next_fval, frand, next_frand;
	logic oen, next_oen, oval, next_oval, orand, next_orand;
	logic [`INSMP_CNT_W-1:0] fcnt, next_fcnt, ocnt, next_ocnt;
	logic [`INSMP_LFSR_W-1:0] lfsr, next_lfsr;
	insmp_fevt_t fres, next_fres;
	logic fcomp, next_fcomp;
	logic [`INSMP_LAT_W-1:0] flat, next_flat;
	logic otagged, next_otagged;
	insmp_oevt_t ores, next_ores;
	logic [31:0] rdata, next_rdata;
	logic bvalid, next_bvalid, rvalid, next_rvalid;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic aw_ok, wr_fire, rd_fire;
	logic [`INSMP_CNT_W-1:0] fmax_full, omax_full;

	assign fmax_full = {fmax, {`INSMP_LOW_W{1'b0}}};
	assign omax_full = {omax, {`INSMP_LOW_W{1'b0}}};
	// Write taken only with address and data together; keeps one write in flight
	assign aw_ok = s_axi_awvalid && s_axi_wvalid && !bvalid;
	assign s_axi_awready = aw_ok;
	assign s_axi_wready = aw_ok;
	assign wr_fire = aw_ok;
	assign s_axi_arready = !rvalid;
	assign rd_fire = s_axi_arvalid && !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign fetch_irq = fval;
	assign op_irq = oval;
	assign op_tag = oen && !oval && !otagged && (ocnt == omax_full) && (omax_full != '0);

	always_comb begin
		next_lfsr = {lfsr[5:0], lfsr[6] ^ lfsr[5]};
		// Lock-up guard should the register ever read zero
		if (lfsr == '0) begin
			next_lfsr = `INSMP_LFSR_SEED;
		end
	end

	// Fetch side
	always_comb begin
		next_fstate = fstate;
		next_fcnt = fcnt;
		next_fres = fres;
		next_fcomp = fcomp;
		next_flat = flat;
		next_fval = fval;
		// count completed fetches, clear at maximum
		if (fen && !fval && fstate == INSMP_F_IDLE && fetch_done) begin
			if (fcnt + 20'h1 >= fmax_full) begin
				next_fcnt = '0;
				next_fstate = INSMP_F_ARMED;
			end else begin
				next_fcnt = fcnt + 20'h1;
			end
		end
		case (fstate)
			INSMP_F_IDLE: begin
			end
			INSMP_F_ARMED: begin
				if (fetch_start) begin
					next_fstate = INSMP_F_TRACK;
					next_fres = fetch_info;
					next_fcomp = 1'b0;
					next_flat = '0;
				end
			end
			INSMP_F_TRACK: begin
				if (flat != '1) begin
					next_flat = flat + 16'h1;
				end
				// physical address and page size arrive later; sticky misses
				if (fetch_update) begin
					next_fres.l1_miss = fres.l1_miss | fetch_upd.l1_miss;
					next_fres.l2_miss = fres.l2_miss | fetch_upd.l2_miss;
					next_fres.ic_miss = fres.ic_miss | fetch_upd.ic_miss;
					if (fetch_upd.phys_valid) begin
						next_fres.phys_valid = 1'b1;
						next_fres.phys_addr = fetch_upd.phys_addr;
						next_fres.page_size = fetch_upd.page_size;
					end
				end
				if (fetch_done || fetch_abort) begin
					next_fcomp = fetch_done;
					next_fval = 1'b1;
					next_fstate = INSMP_F_IDLE;
				end
			end
			default: next_fstate = INSMP_F_IDLE;
		endcase
		if (!fen) begin
			next_fstate = INSMP_F_IDLE;
		end
		// software write of the count register
		if (wr_fire && s_axi_awaddr == `INSMP_OFS_FCNT) begin
			next_fcnt = s_axi_wdata[`INSMP_CNT_W-1:0];
		end
		if (wr_fire && s_axi_awaddr == `INSMP_OFS_FCTL) begin
			// clear only by software; a done in this cycle still wins
			if (!s_axi_wdata[`INSMP_CTL_VAL] && !(fstate == INSMP_F_TRACK
					&& (fetch_done || fetch_abort))) begin
				next_fval = 1'b0;
			end
			if (s_axi_wdata[`INSMP_CTL_RAND]) begin
				next_fcnt[`INSMP_LOW_W-1:0] = lfsr[`INSMP_LOW_W-1:0];
			end
		end
	end

	// Op side
	always_comb begin
		next_ocnt = ocnt;
		next_otagged = otagged;
		next_ores = ores;
		next_oval = oval;
		// count every cycle while enabled and not waiting
		if (oen && !oval && !otagged) begin
			next_ocnt = (ocnt == omax_full) ? ocnt : ocnt + 20'h1;
		end
		if (op_tag && op_tag_taken) begin
			next_otagged = 1'b1;
			next_ocnt = '0;
			next_ores = '0;
		end
		if (otagged) begin
			// sticky events of the tagged op
			if (op_event) begin
				next_ores.pc = op_info.pc;
				next_ores.dc_miss = ores.dc_miss | op_info.dc_miss;
				next_ores.mispredict = ores.mispredict | op_info.mispredict;
				next_ores.branch = ores.branch | op_info.branch;
			end
			if (op_retire) begin
				next_oval = 1'b1;
				next_otagged = 1'b0;
			end else if (op_flush) begin
				next_otagged = 1'b0;
				next_ocnt = {13'h0, lfsr};
			end
		end
		if (!oen) begin
			next_otagged = 1'b0;
		end
		if (wr_fire && s_axi_awaddr == `INSMP_OFS_OCNT) begin
			next_ocnt = s_axi_wdata[`INSMP_CNT_W-1:0];
		end
		if (wr_fire && s_axi_awaddr == `INSMP_OFS_OCTL) begin
			if (!s_axi_wdata[`INSMP_CTL_VAL] && !(otagged && op_retire)) begin
				next_oval = 1'b0;
			end
			if (s_axi_wdata[`INSMP_CTL_RAND]) begin
				next_ocnt[`INSMP_LOW_W-1:0] = lfsr[`INSMP_LOW_W-1:0];
			end
		end
	end

	// Control registers and bus answers
	always_comb begin
		next_fmax = fmax;
		next_fen = fen;
		next_frand = frand;
		next_omax = omax;
		next_oen = oen;
		next_orand = orand;
		next_bvalid = bvalid && !s_axi_bready;
		next_bresp = bresp;
		next_rvalid = rvalid && !s_axi_rready;
		next_rresp = rresp;
		next_rdata = rdata;
		if (wr_fire) begin
			next_bvalid = 1'b1;
			next_bresp = `INSMP_RESP_OKAY;
			case (s_axi_awaddr)
				`INSMP_OFS_FCTL: begin
					next_fmax = s_axi_wdata[`INSMP_MAX_W-1:0];
					next_fen = s_axi_wdata[`INSMP_CTL_EN];
					next_frand = s_axi_wdata[`INSMP_CTL_RAND];
				end
				`INSMP_OFS_OCTL: begin
					next_omax = s_axi_wdata[`INSMP_MAX_W-1:0];
					next_oen = s_axi_wdata[`INSMP_CTL_EN];
					next_orand = s_axi_wdata[`INSMP_CTL_RAND];
				end
				`INSMP_OFS_FCNT, `INSMP_OFS_OCNT: begin
				end
				default: next_bresp = `INSMP_RESP_SLVERR;
			endcase
		end
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rresp = `INSMP_RESP_OKAY;
			case (s_axi_araddr)
				`INSMP_OFS_FCTL: next_rdata = {13'h0, frand, fval, fen, fmax};
				`INSMP_OFS_FLIN: next_rdata = fres.virt_addr;
				`INSMP_OFS_FPHY: next_rdata = fres.phys_addr;
				`INSMP_OFS_FRES: next_rdata = {flat, 9'h0, fres.page_size, fcomp,
					fres.ic_miss, fres.l2_miss, fres.l1_miss, fres.phys_valid};
				`INSMP_OFS_FCNT: next_rdata = {12'h0, fcnt};
				`INSMP_OFS_OCTL: next_rdata = {13'h0, orand, oval, oen, omax};
				`INSMP_OFS_OPC: next_rdata = ores.pc;
				`INSMP_OFS_ORES: next_rdata = {29'h0, ores.branch, ores.mispredict,
					ores.dc_miss};
				`INSMP_OFS_OCNT: next_rdata = {12'h0, ocnt};
				default: begin
					next_rdata = '0;
					next_rresp = `INSMP_RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			fstate <= INSMP_F_IDLE;
			fmax <= '0;
			omax <= '0;
			fen <= 1'b0;
			fval <= 1'b0;
			frand <= 1'b0;
			oen <= 1'b0;
			oval <= 1'b0;
			orand <= 1'b0;
			fcnt <= '0;
			ocnt <= '0;
			lfsr <= `INSMP_LFSR_SEED;
			fres <= '0;
			fcomp <= 1'b0;
			flat <= '0;
			otagged <= 1'b0;
			ores <= '0;
			rdata <= '0;
			bvalid <= 1'b0;
			rvalid <= 1'b0;
			bresp <= '0;
			rresp <= '0;
		end else begin
			fstate <= next_fstate;
			fmax <= next_fmax;
			omax <= next_omax;
			fen <= next_fen;
			fval <= next_fval;
			frand <= next_frand;
			oen <= next_oen;
			oval <= next_oval;
			orand <= next_orand;
			fcnt <= next_fcnt;
			ocnt <= next_ocnt;
			lfsr <= next_lfsr;
			fres <= next_fres;
			fcomp <= next_fcomp;
			flat <= next_flat;
			otagged <= next_otagged;
			ores <= next_ores;
			rdata <= next_rdata;
			bvalid <= next_bvalid;
			rvalid <= next_rvalid;
			bresp <= next_bresp;
			rresp <= next_rresp;
		end
	end

	property p_fetch_irq_on_end;
		@(posedge clk) disable iff (reset)
		(fstate == INSMP_F_TRACK && (fetch_done || fetch_abort)) |=> fetch_irq;
	endproperty
	a_fetch_irq_on_end: assert property (p_fetch_irq_on_end) else $error("no fetch irq");
	property p_comp_flag;
		@(posedge clk) disable iff (reset)
		(fstate == INSMP_F_TRACK && fetch_abort && !fetch_done) |=> !fcomp;
	endproperty
	a_comp_flag: assert property (p_comp_flag) else $error("abort set completion");
	property p_no_tag_pending;
		@(posedge clk) disable iff (reset)
		(fval && fstate == INSMP_F_IDLE) |=> fstate == INSMP_F_IDLE;
	endproperty
	a_no_tag_pending: assert property (p_no_tag_pending) else $error("retag while pending");
	property p_latency_grows;
		@(posedge clk) disable iff (reset)
		(fstate == INSMP_F_TRACK && !fetch_done && !fetch_abort && flat < 16'h10)
			|=> flat == $past(flat) + 16'h1;
	endproperty
	a_latency_grows: assert property (p_latency_grows) else $error("latency stuck");
	property p_op_count;
		@(posedge clk) disable iff (reset)
		(oen && !oval && !otagged && ocnt < 20'h10 && ocnt != omax_full && !wr_fire
			&& !op_tag) |=> ocnt == $past(ocnt) + 20'h1;
	endproperty
	a_op_count: assert property (p_op_count) else $error("op counter stalled");
	property p_flush_no_irq;
		@(posedge clk) disable iff (reset)
		(otagged && op_flush && !op_retire && !oval) |=> !op_irq && ocnt[19:7] == '0;
	endproperty
	a_flush_no_irq: assert property (p_flush_no_irq) else $error("flush gave sample");
	property p_fetch_clear;
		@(posedge clk) disable iff (reset)
		(fstate == INSMP_F_IDLE && fen && !fval && fetch_done && fcnt + 20'h1 >= fmax_full
			&& !wr_fire) |=> fcnt == '0 && fstate == INSMP_F_ARMED;
	endproperty
	a_fetch_clear: assert property (p_fetch_clear) else $error("counter not cleared");
	property p_fetch_count;
		@(posedge clk) disable iff (reset)
		(!fen && !wr_fire) |=> fcnt == $past(fcnt);
	endproperty
	a_fetch_count: assert property (p_fetch_count) else $error("fetch count moved");
	c_fetch_sample: cover property (@(posedge clk) disable iff (reset) $rose(fetch_irq));
	c_op_sample: cover property (@(posedge clk) disable iff (reset) $rose(op_irq));
	c_op_flush: cover property (@(posedge clk) disable iff (reset) otagged && op_flush);
endmodule

// ### tb/insmp_pipe_model.sv
// Pipeline model that drives fetch and op events into the sampling monitor
`timescale 1ns/100ps
module insmp_pipe_model import insmp_pkg::*; #(
	parameter logic [31:0] OP_PC = 32'h0000_4400
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Fetch side
	output logic fetch_start,
	output insmp_fevt_t fetch_info,
	output logic fetch_update,
	output insmp_fupd_t fetch_upd,
	output logic fetch_done,
	output logic fetch_abort,
	// Op side
	input wire logic op_tag,
	output logic op_tag_taken,
	output logic op_event,
	output insmp_oevt_t op_info,
	output logic op_retire,
	output logic op_flush
);
	localparam insmp_oevt_t OPI = {OP_PC, 3'b101};
	logic flush_mode;
	logic [1:0] ost;
	initial begin
		{fetch_start, fetch_update, fetch_done, fetch_abort} = 4'h0;
		{op_tag_taken, op_event, op_retire, op_flush, flush_mode} = 5'h00;
		fetch_info = '0;
		fetch_upd = '0;
		op_info = ~OPI;
		ost = 2'h0;
	end
	// Done or abort lands lat cycles after the start
	task automatic fetch(input int lat, input logic ab, input insmp_fevt_t fi);
		@(posedge clk);
		fetch_start <= 1'b1;
		fetch_info <= fi;
		@(posedge clk);
		fetch_start <= 1'b0;
		fetch_info <= ~fi;
		fetch_update <= 1'b1;
		fetch_upd <= {3'b000, fi.phys_valid, fi.page_size, fi.phys_addr};
		for (int i = 1; i < lat; i++) begin
			@(posedge clk);
			fetch_update <= 1'b0;
			fetch_upd <= ~fetch_upd;
		end
		fetch_done <= !ab;
		fetch_abort <= ab;
		@(posedge clk);
		{fetch_update, fetch_done, fetch_abort} <= 3'b000;
		fetch_upd <= ~fetch_upd;
	endtask
	// Stale data lines toggle so nothing reads a held value by luck
	always @(posedge clk) begin
		op_tag_taken <= (ost == 2'h0) && op_tag && !reset;
		op_event <= (ost == 2'h1);
		op_info <= (ost == 2'h1) ? OPI : ~op_info;
		op_retire <= (ost == 2'h2) && !flush_mode;
		op_flush <= (ost == 2'h2) && flush_mode;
		if (ost != 2'h0 || (op_tag && !reset)) begin
			ost <= (ost == 2'h2) ? 2'h0 : ost + 2'h1;
		end
	end
endmodule

// ### tb/instruction_sampling_monitor_tb.sv
// Self-checking bench for the instruction sampling monitor
`timescale 1ns/100ps
`include "insmp_consts.svh"
`define CHK(nm, e, g) \
	begin \
		checks++; \
		if ((g) !== (e)) begin \
			n_errors++; \
			$display("MISMATCH %s exp %h got %h", nm, e, g); \
		end \
	end
module instruction_sampling_monitor_tb import insmp_pkg::*; ;
	localparam insmp_fevt_t FI1 = {32'h1234_5670, 32'h0abc_d670, 1'b1, 2'b10, 1'b1, 1'b0, 1'b1};
	localparam insmp_fevt_t FI2 = {32'h2000_0040, 32'h0, 1'b0, 2'b00, 1'b0, 1'b1, 1'b0};
	logic clk, reset;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic fetch_start, fetch_update, fetch_done, fetch_abort, fetch_irq, op_irq;
	logic op_tag, op_tag_taken, op_event, op_retire, op_flush;
	insmp_fevt_t fetch_info;
	insmp_fupd_t fetch_upd;
	insmp_oevt_t op_info;
	int n_errors = 0;
	int checks = 0;
	insmp_monitor dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fetch_start,
		.fetch_info, .fetch_update, .fetch_upd, .fetch_done, .fetch_abort, .op_tag,
		.op_tag_taken, .op_event, .op_info, .op_retire, .op_flush, .fetch_irq, .op_irq);
	insmp_pipe_model pipe (.clk, .reset, .fetch_start, .fetch_info, .fetch_update,
		.fetch_upd, .fetch_done, .fetch_abort, .op_tag, .op_tag_taken, .op_event,
		.op_info, .op_retire, .op_flush);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic bus_timeout(input int n);
		if (n >= 50) begin
			n_errors++;
			$display("MISMATCH bus answer exp 1 got 0");
			end_sim();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
			input logic [1:0] er = `INSMP_RESP_OKAY);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 50);
		s_axi_bready <= 1'b0;
		`CHK("bresp", er, s_axi_bresp)
		bus_timeout(n);
	endtask
	task automatic rdr(input logic [11:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 50);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
		bus_timeout(n);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		rdr(a);
		`CHK(nm, e, rd)
		`CHK("rresp", `INSMP_RESP_OKAY, rr)
	endtask
	task automatic plain(input int k);
		repeat (k) pipe.fetch(1, 1'b0, '0);
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return fetch_irq === 1'b1;
			1: return op_tag === 1'b1;
			2: return op_irq === 1'b1;
			default: return op_flush === 1'b1;
		endcase
	endfunction
	task automatic wait_hi(input int s, input int lim);
		int n;
		n = 0;
		while (!sig(s) && n < lim) begin
			@(posedge clk);
			n++;
		end
		if (n >= lim) begin
			n_errors++;
			$display("MISMATCH wait %0d exp 1 got 0", s);
			end_sim();
		end
	endtask
	initial begin
		reset = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 12'h000;
		s_axi_araddr = 12'h000;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rc(`INSMP_OFS_FCTL, 32'h0, "fctl reset");
		rc(`INSMP_OFS_FCNT, 32'h0, "fcnt reset");
		rdr(12'h0fc);
		`CHK("unmapped resp", `INSMP_RESP_SLVERR, rr)
		`CHK("unmapped data", 32'h0, rd)
		wr(12'h0fc, 32'hffff_ffff, `INSMP_RESP_SLVERR);
		rc(`INSMP_OFS_FCTL, 32'h0, "fctl untouched");
		$display("test regs done");
		wr(`INSMP_OFS_FCTL, 32'h0001_0001);
		rc(`INSMP_OFS_FCTL, 32'h0001_0001, "fctl");
		plain(15);
		rc(`INSMP_OFS_FCNT, 32'd15, "fcnt count");
		plain(1);
		rc(`INSMP_OFS_FCNT, 32'h0, "fcnt wrap");
		`CHK("fetch irq early", 1'b0, fetch_irq)
		pipe.fetch(5, 1'b0, FI1);
		wait_hi(0, 10);
		rc(`INSMP_OFS_FLIN, FI1.virt_addr, "vaddr");
		rc(`INSMP_OFS_FPHY, FI1.phys_addr, "paddr");
		rc(`INSMP_OFS_FRES, 32'h0005_005b, "fres done");
		rdr(`INSMP_OFS_FCTL);
		`CHK("fetch valid", 1'b1, rd[`INSMP_CTL_VAL])
		plain(20);
		rc(`INSMP_OFS_FCNT, 32'h0, "fcnt held");
		rc(`INSMP_OFS_FLIN, FI1.virt_addr, "vaddr held");
		wr(`INSMP_OFS_FCNT, 32'h0);
		wr(`INSMP_OFS_FCTL, 32'h0001_0001);
		`CHK("fetch irq cleared", 1'b0, fetch_irq)
		plain(16);
		pipe.fetch(3, 1'b1, FI2);
		wait_hi(0, 10);
		rc(`INSMP_OFS_FRES, 32'h0003_0004, "fres abort");
		rc(`INSMP_OFS_FLIN, FI2.virt_addr, "vaddr abort");
		$display("test fetch done");
		// Op sampling runs while the fetch sample is still pending
		pipe.flush_mode <= 1'b1;
		wr(`INSMP_OFS_OCTL, 32'h0001_0010);
		rdr(`INSMP_OFS_FCTL);
		`CHK("fctl max kept", 16'h0001, rd[15:0])
		`CHK("fctl valid kept", 1'b1, rd[`INSMP_CTL_VAL])
		wait_hi(1, 300);
		wait_hi(3, 10);
		pipe.flush_mode <= 1'b0;
		wait_hi(1, 400);
		`CHK("op irq after flush", 1'b0, op_irq)
		wait_hi(2, 10);
		rc(`INSMP_OFS_OPC, 32'h0000_4400, "op pc");
		rc(`INSMP_OFS_ORES, 32'h5, "op flags");
		rc(`INSMP_OFS_OCTL, 32'h0003_0010, "octl valid");
		$display("test op done");
		// count rewrite holds while the op sample is pending
		wr(`INSMP_OFS_OCNT, 32'h0000_0123);
		rc(`INSMP_OFS_OCNT, 32'h0000_0123, "ocnt write");
		wr(`INSMP_OFS_OCTL, 32'h0004_0010);
		`CHK("op irq cleared", 1'b0, op_irq)
		rdr(`INSMP_OFS_OCNT);
		`CHK("ocnt random high", 28'h000_0012, rd[31:4])
		wr(`INSMP_OFS_FCTL, 32'h0005_0001);
		rdr(`INSMP_OFS_FCNT);
		`CHK("fcnt random high", 28'h0, rd[31:4])
		$display("test random done");
		end_sim();
	end
endmodule
